//--- design/wsg_map.vh
// Register map, field layout and timing constants of the waveform setpoint generator
`ifndef WSG_MAP_VH
`define WSG_MAP_VH
`define WSG_A_CTRL      8'h00
`define WSG_A_STATUS    8'h04
`define WSG_A_FUNC      8'h08
`define WSG_A_AMPL      8'h0C
`define WSG_A_OFFS      8'h10
`define WSG_A_T1        8'h14
`define WSG_A_T2        8'h18
`define WSG_A_FREQ      8'h1C
`define WSG_A_USTAT     8'h20
`define WSG_A_ISTAT     8'h24
`define WSG_A_PSTAT     8'h28
`define WSG_A_ISINK     8'h2C
`define WSG_A_VEXT      8'h30
`define WSG_A_SETPT     8'h34
`define WSG_B_START     0
`define WSG_B_STOP      1
`define WSG_B_CFG_DONE  2
`define WSG_B_ALM_CLR   3
`define WSG_B_CFG_ENTER 4
`define WSG_FN_SINE     2'h0
`define WSG_FN_TRI      2'h1
`define WSG_FN_RECT     2'h2
`define WSG_TICK_NS     100000
`define WSG_CLK_NS      100
`define WSG_TMAX_TICKS  32'h15752A00
`define WSG_FMAX_HZ     16'h2710
`define WSG_TICK_HZ     32'h00002710
`define WSG_RESP_OK     2'h0
`define WSG_RESP_SLVERR 2'h2
`endif

//--- design/wsg_top.v
// Waveform setpoint generator with AXI4-Lite register access
//
// Local design decisions: the AXI4-Lite register port and the register offsets.
`include "wsg_map.vh"
`default_nettype none
module wsg_top #(
    parameter        DW        = 16,
    parameter [15:0] RATED     = 16'hFFFF,
    parameter [31:0] TICK_CYC  = `WSG_TICK_NS / `WSG_CLK_NS
) (
    input  wire        CLK,
    input  wire        RESET,
    input  wire [7:0]  S_AXI_AWADDR,
    input  wire        S_AXI_AWVALID,
    output reg         S_AXI_AWREADY,
    input  wire [31:0] S_AXI_WDATA,
    input  wire [3:0]  S_AXI_WSTRB,
    input  wire        S_AXI_WVALID,
    output reg         S_AXI_WREADY,
    output reg  [1:0]  S_AXI_BRESP,
    output reg         S_AXI_BVALID,
    input  wire        S_AXI_BREADY,
    input  wire [7:0]  S_AXI_ARADDR,
    input  wire        S_AXI_ARVALID,
    output reg         S_AXI_ARREADY,
    output reg  [31:0] S_AXI_RDATA,
    output reg  [1:0]  S_AXI_RRESP,
    output reg         S_AXI_RVALID,
    input  wire        S_AXI_RREADY,
    input  wire        ONOFF_BUTTON,
    input  wire        R_MODE_ON,
    input  wire        DEVICE_ALARM,
    input  wire        OVERPOWER_TRIP,
    input  wire        OVERCURRENT_TRIP,
    input  wire        EVENT_ALARM,
    output reg         OUTPUT_ON,
    output reg         ALARM_OUT,
    output reg  [15:0] U_SET,
    output reg  [15:0] I_SET,
    output reg  [15:0] P_SET,
    output reg  [15:0] I_SINK_SET,
    output reg         SINK_ALLOWED
);
    // Controller states, one-hot
    localparam [3:0] ST_OFF = 4'b0001;
    localparam [3:0] ST_CFG = 4'b0010;
    localparam [3:0] ST_RDY = 4'b0100;
    localparam [3:0] ST_RUN = 4'b1000;

    reg [3:0]  state_r, state_nxt;
    reg [1:0]  func_r;
    reg [15:0] ampl_r, offs_r, freq_r, wave_r;
    reg [15:0] ustat_r, istat_r, pstat_r, isink_r, vext_r;
    reg [31:0] t1_r, t2_r, tick_cnt_r, phase_r, sacc_r, wdata_r;
    reg [7:0]  awaddr_r;
    reg [4:0]  ctl_pulse_r;
    reg        tgt_cur_r, alarm_r, refused_r, btn_d_r;
    reg        tick_r, seg_r, aw_ok_r, w_ok_r;

    wire       btn_press = ONOFF_BUTTON & ~btn_d_r;
    wire       alarm_in  = DEVICE_ALARM | OVERPOWER_TRIP | OVERCURRENT_TRIP | EVENT_ALARM;
    wire       cfg_open  = state_r == ST_CFG;
    wire       wr_fire   = aw_ok_r & w_ok_r & ~S_AXI_BVALID;
    wire       run_live  = state_r == ST_RUN;
    wire [16:0] peak     = {1'b0, offs_r} + {1'b0, ampl_r};

    // Scale a 16-bit fraction (0..FFFF) of amplitude, used by the triangle and sine shapes
    function [15:0] scale;
        input [15:0] a;
        input [15:0] f;
        reg   [31:0] p;
        begin
            p     = a * f;
            scale = p[31:16];
        end
    endfunction

    // Ratio of elapsed phase to interval length, as a 16-bit fraction
    function [15:0] frac;
        input [31:0] num;
        input [31:0] den;
        reg   [47:0] q;
        begin
            q = (den == 32'h0) ? 48'h0 : ({num, 16'h0} / {16'h0, den});
            frac = (q > 48'h0000_0000_FFFF) ? 16'hFFFF : q[15:0];
        end
    endfunction

    // Clamp a parameter into the legal interval range
    function [31:0] clamp_t;
        input [31:0] v;
        begin
            if (v == 32'h0) begin
                clamp_t = 32'h1;
            end else if (v > `WSG_TMAX_TICKS) begin
                clamp_t = `WSG_TMAX_TICKS;
            end else begin
                clamp_t = v;
            end
        end
    endfunction

    // Control state machine; alarm dominates every other request
    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_OFF: begin
                if (ctl_pulse_r[`WSG_B_CFG_ENTER] & ~R_MODE_ON) begin
                    state_nxt = ST_CFG;
                end else if (btn_press & ~alarm_r) begin
                    state_nxt = ST_RUN;
                end
            end
            ST_CFG: begin
                if (R_MODE_ON) begin
                    state_nxt = ST_OFF;
                end else if (ctl_pulse_r[`WSG_B_CFG_DONE]) begin
                    state_nxt = ST_RDY;
                end
            end
            ST_RDY: begin
                if (btn_press) begin
                    state_nxt = ST_OFF;
                end else if (ctl_pulse_r[`WSG_B_START]) begin
                    state_nxt = ST_RUN;
                end
            end
            ST_RUN: begin
                if (btn_press) begin
                    state_nxt = ST_OFF;
                end else if (ctl_pulse_r[`WSG_B_STOP]) begin
                    state_nxt = ST_RDY;
                end
            end
            default: state_nxt = ST_OFF;
        endcase
        if (alarm_in) begin
            state_nxt = ST_OFF;
        end
    end

    always @(posedge CLK) begin
        if (RESET) begin
            state_r   <= ST_OFF;
            alarm_r   <= 1'b0;
            btn_d_r   <= 1'b0;
            refused_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            btn_d_r <= ONOFF_BUTTON;
            // Trip wins over a clear in the same cycle
            if (alarm_in) begin
                alarm_r <= 1'b1;
            end else if (ctl_pulse_r[`WSG_B_ALM_CLR]) begin
                alarm_r <= 1'b0;
            end
            if (ctl_pulse_r[`WSG_B_CFG_ENTER] & (R_MODE_ON | state_r != ST_OFF)) begin
                refused_r <= 1'b1;
            end else if (ctl_pulse_r[`WSG_B_ALM_CLR]) begin
                refused_r <= 1'b0;
            end
        end
    end

    // Internal update tick; all intervals count in ticks of 0.1 ms
    always @(posedge CLK) begin
        if (RESET) begin
            tick_cnt_r <= 32'h0;
            tick_r     <= 1'b0;
        end else if (tick_cnt_r >= TICK_CYC - 32'h1) begin
            tick_cnt_r <= 32'h0;
            tick_r     <= 1'b1;
        end else begin
            tick_cnt_r <= tick_cnt_r + 32'h1;
            tick_r     <= 1'b0;
        end
    end

    // Phase and segment: t1 then t2 makes one period
    always @(posedge CLK) begin
        if (RESET | ~run_live) begin
            phase_r <= 32'h0;
            seg_r   <= 1'b0;
            sacc_r  <= 32'h0;
        end else if (tick_r) begin
            sacc_r <= sacc_r + {16'h0, freq_r};
            if (phase_r + 32'h1 >= (seg_r ? clamp_t(t2_r) : clamp_t(t1_r))) begin
                phase_r <= 32'h0;
                seg_r   <= ~seg_r;
            end else begin
                phase_r <= phase_r + 32'h1;
            end
            if (sacc_r + {16'h0, freq_r} >= `WSG_TICK_HZ) begin
                sacc_r <= sacc_r + {16'h0, freq_r} - `WSG_TICK_HZ;
            end
        end
    end

    // Sine phase folded into a wedge; the parabola peaks at one amplitude
    wire [15:0] sine_ph    = (sacc_r[15:0] == 16'h0) ? 16'h0 : frac(sacc_r, `WSG_TICK_HZ);
    wire [15:0] sine_wedge = sine_ph[15] ? ~{sine_ph[14:0], 1'b0} : {sine_ph[14:0], 1'b0};
    wire [15:0] sine_half  = scale(ampl_r, scale(sine_wedge, ~sine_wedge) << 2);

    // Waveform value; sine uses a parabolic approximation around the offset
    always @(posedge CLK) begin
        if (RESET) begin
            wave_r <= 16'h0;
        end else begin
            case (func_r)
                `WSG_FN_TRI: begin
                    wave_r <= offs_r + scale(ampl_r, seg_r ? ~frac(phase_r, clamp_t(t2_r))
                                                   : frac(phase_r, clamp_t(t1_r)));
                end
                `WSG_FN_RECT: begin
                    wave_r <= seg_r ? offs_r : offs_r + ampl_r;
                end
                default: begin
                    wave_r <= sine_ph[15] ? offs_r - sine_half : offs_r + sine_half;
                end
            endcase
        end
    end

    // Output set values; static globals outside a run, unmodulated ones always limits
    always @(posedge CLK) begin
        if (RESET) begin
            OUTPUT_ON    <= 1'b0;
            ALARM_OUT    <= 1'b0;
            U_SET        <= 16'h0;
            I_SET        <= 16'h0;
            P_SET        <= 16'h0;
            I_SINK_SET   <= 16'h0;
            SINK_ALLOWED <= 1'b0;
        end else begin
            OUTPUT_ON  <= (state_r == ST_RDY) | run_live;
            ALARM_OUT  <= alarm_r;
            P_SET      <= pstat_r;
            I_SINK_SET <= isink_r;
            U_SET      <= (run_live & ~tgt_cur_r) ? wave_r : ustat_r;
            I_SET      <= (run_live & tgt_cur_r) ? wave_r : istat_r;
            if (run_live & ~tgt_cur_r) begin
                SINK_ALLOWED <= ({1'b0, vext_r} > peak) & (isink_r != 16'h0);
            end else begin
                SINK_ALLOWED <= isink_r != 16'h0;
            end
        end
    end

    // AXI4-Lite write channel: address and data taken in either order
    always @(posedge CLK) begin
        if (RESET) begin
            S_AXI_AWREADY <= 1'b0;
            S_AXI_WREADY  <= 1'b0;
            S_AXI_BVALID  <= 1'b0;
            S_AXI_BRESP   <= `WSG_RESP_OK;
            aw_ok_r       <= 1'b0;
            w_ok_r        <= 1'b0;
            awaddr_r      <= 8'h0;
            wdata_r       <= 32'h0;
            ctl_pulse_r   <= 5'h0;
            func_r        <= `WSG_FN_SINE;
            tgt_cur_r     <= 1'b0;
            ampl_r        <= 16'h0;
            offs_r        <= 16'h0;
            t1_r          <= 32'h1;
            t2_r          <= 32'h1;
            freq_r        <= 16'h1;
            ustat_r       <= 16'h0;
            istat_r       <= 16'h0;
            pstat_r       <= 16'h0;
            isink_r       <= 16'h0;
            vext_r        <= 16'h0;
        end else begin
            ctl_pulse_r   <= 5'h0;
            S_AXI_AWREADY <= ~aw_ok_r & ~S_AXI_AWREADY & S_AXI_AWVALID;
            S_AXI_WREADY  <= ~w_ok_r & ~S_AXI_WREADY & S_AXI_WVALID;
            if (S_AXI_AWVALID & S_AXI_AWREADY) begin
                aw_ok_r  <= 1'b1;
                awaddr_r <= S_AXI_AWADDR;
            end
            if (S_AXI_WVALID & S_AXI_WREADY) begin
                w_ok_r  <= 1'b1;
                wdata_r <= S_AXI_WDATA;
            end
            if (S_AXI_BVALID & S_AXI_BREADY) begin
                S_AXI_BVALID <= 1'b0;
            end
            if (wr_fire) begin
                aw_ok_r      <= 1'b0;
                w_ok_r       <= 1'b0;
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP  <= `WSG_RESP_OK;
                case (awaddr_r)
                    `WSG_A_CTRL: ctl_pulse_r <= wdata_r[4:0];
                    `WSG_A_FUNC: begin
                        if (cfg_open) begin
                            func_r    <= wdata_r[1:0];
                            tgt_cur_r <= wdata_r[4];
                        end
                    end
                    `WSG_A_AMPL: begin
                        // Offset plus amplitude never passes the rating
                        if (cfg_open | run_live | state_r == ST_RDY) begin
                            ampl_r <= ({1'b0, offs_r} + {1'b0, wdata_r[15:0]} > {1'b0, RATED})
                                      ? RATED - offs_r : wdata_r[15:0];
                        end
                    end
                    `WSG_A_OFFS: begin
                        if (state_r != ST_OFF) begin
                            offs_r <= ({1'b0, ampl_r} + {1'b0, wdata_r[15:0]} > {1'b0, RATED})
                                      ? RATED - ampl_r : wdata_r[15:0];
                        end
                    end
                    `WSG_A_T1:   if (state_r != ST_OFF) t1_r <= clamp_t(wdata_r);
                    `WSG_A_T2:   if (state_r != ST_OFF) t2_r <= clamp_t(wdata_r);
                    `WSG_A_FREQ: begin
                        if (state_r != ST_OFF) begin
                            freq_r <= (wdata_r[15:0] > `WSG_FMAX_HZ) ? `WSG_FMAX_HZ
                                    : (wdata_r[15:0] == 16'h0 ? 16'h1 : wdata_r[15:0]);
                        end
                    end
                    `WSG_A_USTAT: ustat_r <= wdata_r[15:0];
                    `WSG_A_ISTAT: istat_r <= wdata_r[15:0];
                    `WSG_A_PSTAT: pstat_r <= wdata_r[15:0];
                    `WSG_A_ISINK: isink_r <= wdata_r[15:0];
                    `WSG_A_VEXT:  vext_r  <= wdata_r[15:0];
                    `WSG_A_STATUS: ;
                    `WSG_A_SETPT:  ;
                    default: S_AXI_BRESP <= `WSG_RESP_SLVERR;
                endcase
            end
        end
    end

    // AXI4-Lite read channel; one cycle from address to data
    always @(posedge CLK) begin
        if (RESET) begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID  <= 1'b0;
            S_AXI_RDATA   <= 32'h0;
            S_AXI_RRESP   <= `WSG_RESP_OK;
        end else begin
            S_AXI_ARREADY <= ~S_AXI_ARREADY & ~S_AXI_RVALID & S_AXI_ARVALID;
            if (S_AXI_RVALID & S_AXI_RREADY) begin
                S_AXI_RVALID <= 1'b0;
            end
            if (S_AXI_ARVALID & S_AXI_ARREADY) begin
                S_AXI_RVALID <= 1'b1;
                S_AXI_RRESP  <= `WSG_RESP_OK;
                case (S_AXI_ARADDR)
                    `WSG_A_CTRL:   S_AXI_RDATA <= 32'h0;
                    `WSG_A_STATUS: S_AXI_RDATA <= {24'h0, SINK_ALLOWED, refused_r, alarm_r, OUTPUT_ON, state_r};
                    `WSG_A_FUNC:   S_AXI_RDATA <= {27'h0, tgt_cur_r, 2'h0, func_r};
                    `WSG_A_AMPL:   S_AXI_RDATA <= {16'h0, ampl_r};
                    `WSG_A_OFFS:   S_AXI_RDATA <= {16'h0, offs_r};
                    `WSG_A_T1:     S_AXI_RDATA <= t1_r;
                    `WSG_A_T2:     S_AXI_RDATA <= t2_r;
                    `WSG_A_FREQ:   S_AXI_RDATA <= {16'h0, freq_r};
                    `WSG_A_USTAT:  S_AXI_RDATA <= {16'h0, ustat_r};
                    `WSG_A_ISTAT:  S_AXI_RDATA <= {16'h0, istat_r};
                    `WSG_A_PSTAT:  S_AXI_RDATA <= {16'h0, pstat_r};
                    `WSG_A_ISINK:  S_AXI_RDATA <= {16'h0, isink_r};
                    `WSG_A_VEXT:   S_AXI_RDATA <= {16'h0, vext_r};
                    `WSG_A_SETPT:  S_AXI_RDATA <= {16'h0, wave_r};
                    default: begin
                        S_AXI_RDATA <= 32'h0;
                        S_AXI_RRESP <= `WSG_RESP_SLVERR;
                    end
                endcase
            end
        end
    end
endmodule
`default_nettype wire

//--- dv/wsg_top_checker.sv
// Port-level assertions for the waveform setpoint generator
`default_nettype none
module wsg_top_checker (
    input wire logic        CLK,
    input wire logic        RESET,
    input wire logic        S_AXI_AWREADY,
    input wire logic        S_AXI_WREADY,
    input wire logic        S_AXI_BVALID,
    input wire logic        S_AXI_BREADY,
    input wire logic [7:0]  S_AXI_ARADDR,
    input wire logic        S_AXI_ARVALID,
    input wire logic        S_AXI_ARREADY,
    input wire logic [31:0] S_AXI_RDATA,
    input wire logic [1:0]  S_AXI_RRESP,
    input wire logic        S_AXI_RVALID,
    input wire logic        ONOFF_BUTTON,
    input wire logic        DEVICE_ALARM,
    input wire logic        OVERPOWER_TRIP,
    input wire logic        OVERCURRENT_TRIP,
    input wire logic        EVENT_ALARM,
    input wire logic        OUTPUT_ON,
    input wire logic        ALARM_OUT
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge CLK); endclocking
    default disable iff (RESET);
    logic       alm;
    logic       btn_d_r;
    logic [3:0] age_b_r;
    logic [3:0] age_p_r;
    assign alm = DEVICE_ALARM | OVERPOWER_TRIP | OVERCURRENT_TRIP | EVENT_ALARM;
    // Ages of the last write response and last press; reset makes them old so nothing excuses a switch-on
    always_ff @(posedge CLK) begin
        btn_d_r <= ONOFF_BUTTON;
        age_b_r <= (S_AXI_BVALID && S_AXI_BREADY) ? 4'h0 : (RESET ? 4'hF : age_b_r + {3'h0, ~&age_b_r});
        age_p_r <= (ONOFF_BUTTON && !btn_d_r) ? 4'h0 : (RESET ? 4'hF : age_p_r + {3'h0, ~&age_p_r});
    end
    sequence ar_take;
        S_AXI_ARVALID && S_AXI_ARREADY;
    endsequence
    sequence wr_take;
        S_AXI_AWREADY && S_AXI_WREADY;
    endsequence
    reset_clear_a: assert property ($fell(RESET) |-> !OUTPUT_ON && !ALARM_OUT) else $error("reset left outputs set");
    alarm_off_a: assert property (alm |-> ##[1:4] !OUTPUT_ON) else $error("fault kept output on");
    alarm_report_a: assert property (alm |-> ##[1:4] ALARM_OUT) else $error("fault not reported");
    alarm_clear_a: assert property ($fell(ALARM_OUT) && !$past(RESET) |-> !$past(alm) && age_b_r < 4'h8)
        else $error("alarm dropped without clear");
    output_cause_a: assert property ($rose(OUTPUT_ON) && !$past(RESET) |-> age_b_r < 4'h8 || age_p_r < 4'h8)
        else $error("output on without cause");
    read_lat_a: assert property (ar_take |=> S_AXI_RVALID) else $error("read answer late");
    write_lat_a: assert property (wr_take |-> ##[1:3] S_AXI_BVALID) else $error("write answer late");
    ready_pulse_a: assert property (S_AXI_ARREADY |=> !S_AXI_ARREADY) else $error("read ready too long");
    unmapped_rd_a: assert property (S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR > 8'h34
        |=> S_AXI_RRESP == 2'h2 && S_AXI_RDATA == 32'h0) else $error("unmapped read not refused");
endmodule
bind wsg_top wsg_top_checker i_wsg_top_checker (.CLK(CLK), .RESET(RESET), .S_AXI_AWREADY(S_AXI_AWREADY),
    .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
    .S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
    .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RRESP(S_AXI_RRESP), .S_AXI_RVALID(S_AXI_RVALID),
    .ONOFF_BUTTON(ONOFF_BUTTON), .DEVICE_ALARM(DEVICE_ALARM), .OVERPOWER_TRIP(OVERPOWER_TRIP),
    .OVERCURRENT_TRIP(OVERCURRENT_TRIP), .EVENT_ALARM(EVENT_ALARM), .OUTPUT_ON(OUTPUT_ON), .ALARM_OUT(ALARM_OUT));
`default_nettype wire

//--- dv/wsg_panel.sv
// Operator panel model: On/Off button, resistance mode switch and fault sources
`default_nettype none
module wsg_panel (
    input  wire logic       CLK,
    output var  logic       ONOFF_BUTTON = 1'b0,
    output var  logic       R_MODE_ON = 1'b0,
    output var  logic [3:0] FAULT = 4'h0
);
    timeunit 1ns;
    timeprecision 1ns;
    // One press is a rising edge held two cycles, so the edge detector cannot miss it
    task automatic press();
        @(posedge CLK);
        ONOFF_BUTTON <= 1'b1;
        repeat (2) @(posedge CLK);
        ONOFF_BUTTON <= 1'b0;
    endtask
    // Resistance mode is a plain level
    task automatic rmode(input logic v);
        @(posedge CLK);
        R_MODE_ON <= v;
    endtask
    // Fault sources: device alarm, overpower, overcurrent, event alarm
    task automatic trip(input int k, input logic v);
        @(posedge CLK);
        FAULT[k] <= v;
    endtask
endmodule
`default_nettype wire

//--- dv/test_wsg_top.sv
// Bench: register tasks, state model and waveform probes for the setpoint generator
`default_nettype none
`include "wsg_map.vh"
module test_wsg_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int TC = 4; // Short tick keeps waveform periods brief
    logic        CLK = 1'b0;
    logic        RESET = 1'b1;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, rd;
    logic [2:0]  rr;
    logic [1:0]  bresp, rresp;
    logic [3:0]  flt;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        btn, rmo, awready, wready, bvalid, arready, rvalid, on, alo, sink;
    logic [15:0] u_set, i_set, p_set, i_sink;
    int          error_cnt = 0, num_checks = 0, cyc = 0;
    int          m_st = 1, m_on = 0, m_alm = 0, m_ref = 0, m_rm = 0;
    wsg_top #(.TICK_CYC(TC)) i_wsg_top (.CLK(CLK), .RESET(RESET), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
        .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid),
        .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
        .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .ONOFF_BUTTON(btn), .R_MODE_ON(rmo),
        .DEVICE_ALARM(flt[0]), .OVERPOWER_TRIP(flt[1]), .OVERCURRENT_TRIP(flt[2]), .EVENT_ALARM(flt[3]),
        .OUTPUT_ON(on), .ALARM_OUT(alo), .U_SET(u_set), .I_SET(i_set), .P_SET(p_set), .I_SINK_SET(i_sink),
        .SINK_ALLOWED(sink));
    wsg_panel i_wsg_panel (.CLK(CLK), .ONOFF_BUTTON(btn), .R_MODE_ON(rmo), .FAULT(flt));
    always #50 CLK = ~CLK;
    // Cycle count doubles as the time base for waveform probes and as the hang limit
    always @(posedge CLK) begin
        cyc <= cyc + 1;
        if (cyc > 20000) begin
            error_cnt++;
            summarize();
        end
    end
    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Write: both channels offered together, each released at its own handshake
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge CLK);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge CLK);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        cmp("bresp", 32'h4, {29'h0, bvalid, bresp});
    endtask
    task automatic rdr(input logic [7:0] a);
        @(posedge CLK);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge CLK);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
        rd = rdata;
        rr = {rvalid, rresp};
    endtask
    // Event: bus command or button press (5) driven here, fault (6) already driven by the caller, then the model's step
    task automatic ev(input int b);
        if (b < 5) wr(`WSG_A_CTRL, 32'h1 << b);
        else if (b == 5) i_wsg_panel.press();
        case (b)
            `WSG_B_START: if (m_st == 4) m_st = 8;
            `WSG_B_STOP: if (m_st == 8) m_st = 4;
            `WSG_B_CFG_DONE: if (m_st == 2) {m_st, m_on} = {32'd4, 32'd1};
            `WSG_B_ALM_CLR: {m_alm, m_ref} = {32'd0, 32'd0};
            `WSG_B_CFG_ENTER: if (m_rm || m_st != 1) m_ref = 1; else m_st = 2;
            5: {m_st, m_on} = (m_st == 1) ? {32'd8, 32'd1} : {32'd1, 32'd0};
            default: {m_st, m_on, m_alm} = {32'd1, 32'd0, 32'd1};
        endcase
        repeat (4) @(posedge CLK);
    endtask
    task automatic chk();
        rdr(`WSG_A_STATUS);
        cmp("status", m_st | m_on << 4 | m_alm << 5 | m_ref << 6, {25'h0, rd[6:0]});
        cmp("output_on", m_on, 32'(on));
        cmp("alarm_out", m_alm, 32'(alo));
    endtask
    task automatic wu(input logic [15:0] v);
        int n;
        n = 0;
        while (u_set !== v && n < 400) begin
            @(posedge CLK);
            n++;
        end
    endtask
    // One shape: configure, run, probe, stop; sine drives current, the others voltage
    task automatic shape(input int s);
        logic [15:0] a, o, us, is, mn, mx, v, hi, lo;
        logic [31:0] fn, dd[10];
        logic [7:0]  aa[10];
        int          t1, t2, t0, th, bad;
        a = 16'h10 + 16'($urandom_range(0, 63));
        o = a + 16'($urandom_range(0, 99));
        t1 = $urandom_range(1, 4);
        t2 = $urandom_range(1, 4);
        us = 16'h0400 + 16'($urandom_range(0, 255));
        is = 16'h0300;
        fn = (s == 0) ? 32'h10 : 32'(s);
        hi = o + a;
        lo = (s == 0) ? o - a : o;
        aa = '{`WSG_A_FUNC, `WSG_A_AMPL, `WSG_A_OFFS, `WSG_A_T1, `WSG_A_T2, `WSG_A_FREQ, `WSG_A_USTAT,
               `WSG_A_ISTAT, `WSG_A_PSTAT, `WSG_A_ISINK};
        dd = '{fn, a, o, t1, t2, 32'h3E8, us, is, 32'h7000, 32'h5};
        ev(`WSG_B_CFG_ENTER);
        chk();
        for (int k = 0; k < 10; k++) wr(aa[k], dd[k]);
        wr(`WSG_A_VEXT, 32'(hi + 16'h1));
        rdr(`WSG_A_FUNC);
        cmp("func", fn, rd);
        ev(`WSG_B_CFG_DONE);
        chk();
        cmp("u_before", us, u_set);
        wr(`WSG_A_FUNC, 32'h12);
        rdr(`WSG_A_FUNC);
        cmp("func_locked", fn, rd);
        ev(`WSG_B_START);
        chk();
        {mn, mx, bad} = {16'hFFFF, 16'h0, 32'd0};
        repeat (300) begin
            @(posedge CLK);
            v = (s == 0) ? i_set : u_set;
            if (v < mn) mn = v;
            if (v > mx) mx = v;
            if (((s == 0) ? u_set : i_set) !== ((s == 0) ? us : is)) bad++;
        end
        cmp("static", 0, bad);
        cmp("p_set", 32'h7000, 32'(p_set));
        cmp("i_sink", 32'h5, 32'(i_sink));
        cmp("low", 1, 32'(mn >= lo));
        cmp("high", 1, 32'(mx <= hi && mx > mn));
        // Sink checks come before the offset change, which would lift the peak onto the external voltage
        if (s != 0) begin
            cmp("sink_on", 1, 32'(sink));
            wr(`WSG_A_VEXT, 32'(hi));
            repeat (4) @(posedge CLK);
            cmp("sink_off", 0, 32'(sink));
        end
        if (s == 2) begin
            wu(lo);
            wu(hi);
            t0 = cyc;
            wu(lo);
            th = cyc - t0;
            wu(hi);
            cmp("pulse", t1 * TC, th);
            cmp("period", (t1 + t2) * TC, cyc - t0);
            wr(`WSG_A_OFFS, 32'(o + 16'h1));
            wu(lo + 16'h1);
            cmp("new_base", 32'(lo + 16'h1), 32'(u_set));
        end
        ev(`WSG_B_STOP);
        chk();
        cmp("u_after", us, u_set);
        ev(5);
        chk();
    endtask
    initial begin
        void'($urandom(97));
        repeat (5) @(posedge CLK);
        RESET <= 1'b0;
        chk();
        rdr(8'hFC);
        cmp("unmapped", 32'h6, {29'h0, rr});
        cmp("unmapped_data", 32'h0, rd);
        i_wsg_panel.rmode(1'b1);
        m_rm = 1;
        ev(`WSG_B_CFG_ENTER);
        chk();
        i_wsg_panel.rmode(1'b0);
        m_rm = 0;
        ev(`WSG_B_ALM_CLR);
        for (int s = 0; s < 3; s++) shape(s);
        ev(5);
        chk();
        ev(`WSG_B_CFG_ENTER);
        chk();
        ev(5);
        chk();
        for (int k = 0; k < 4; k++) begin
            ev(5);
            i_wsg_panel.trip(k, 1'b1);
            ev(6);
            chk();
            i_wsg_panel.trip(k, 1'b0);
            ev(`WSG_B_ALM_CLR);
            chk();
        end
        summarize();
    end
endmodule
`default_nettype wire
